/* inc/flash_host_regs.svh */
/*
   Constants of the flash status controller: register offsets and fields of the
   software-facing registers, flash command bytes, status bit positions on the
   data pins and the bus-cycle timing.
   Assumes a 20 MHz system clock and a byte-wide asynchronous flash.
*/
`ifndef FLASH_HOST_REGS_SVH
`define FLASH_HOST_REGS_SVH

// flash geometry
`define FLASH_ADDR_W 22
`define FLASH_DATA_W 8

// register byte offsets on the wishbone side
`define OFF_CTRL 8'h00
`define OFF_ADDR 8'h04
`define OFF_WDATA 8'h08
`define OFF_STATUS 8'h0C
`define OFF_STAT_ADDR 8'h10

// control register fields
`define CTRL_OP_MSB 2
`define CTRL_OP_LSB 0
`define CTRL_SKIP_WIN_BIT 4

// status register fields
`define STAT_BUSY_BIT 0
`define STAT_DONE_BIT 1
`define STAT_FAIL_BIT 2
`define STAT_LATE_BIT 3
`define STAT_LOST_BIT 4
`define STAT_RDY_BIT 5
`define STAT_LAST_LSB 8
`define STAT_LAST_MSB 15

// command bytes written to the flash
`define FL_CMD_RESET 8'hF0
`define FL_CMD_SECT_ERASE 8'h30

// status bit positions on the flash data pins
`define DQ_POLL_BIT 7
`define DQ_TOGGLE_BIT 6
`define DQ_TOUT_BIT 5
`define DQ_WIN_BIT 3
`define DQ_STOG_BIT 2

// bus-cycle timing
`define CLK_PERIOD_NS 50
`define T_ACC_NS 70
`define T_WP_NS 35
`define T_ACC_CYC ((`T_ACC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_WP_CYC ((`T_WP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* inc/flash_host_pkg.sv */
/*
   Types of the flash status controller: pin bundle, operation codes and
   state encodings.
   Assumes flash_host_regs.svh on the include path.
*/
`include "flash_host_regs.svh"

package flash_host_pkg;

   // everything the controller drives toward the flash
   typedef struct packed {
      logic [`FLASH_ADDR_W-1:0] addr;
      logic [`FLASH_DATA_W-1:0] dq_out;
      logic dq_oe;
      logic ce_n;
      logic oe_n;
      logic we_n;
   } flash_pins_type;

   // operations software can start through the control register
   typedef enum logic [2:0] {
      OP_NONE = 3'h0,
      OP_WRITE = 3'h1,
      OP_READ = 3'h2,
      OP_POLL = 3'h3,
      OP_SECTOR = 3'h4
   } op_type;

   // single bus-cycle engine
   typedef enum logic [3:0] {
      E_IDLE = 4'h1,
      E_SETUP = 4'h2,
      E_STROBE = 4'h4,
      E_HOLD = 4'h8
   } eng_state_type;

   // operation sequencer
   typedef enum logic [8:0] {
      M_IDLE = 9'h001,
      M_XFER = 9'h002,
      M_P_FIRST = 9'h004,
      M_P_NEXT = 9'h008,
      M_P_RECHK = 9'h010,
      M_P_RST = 9'h020,
      M_S_PRE = 9'h040,
      M_S_WR = 9'h080,
      M_S_POST = 9'h100
   } seq_state_type;

endpackage

/* src/flash_cycle_engine.sv */
/*
   One asynchronous flash bus cycle, read or write, with chip enable framing
   every cycle so that each read is a separate read cycle to the flash.
   Assumes the flash data pins are synchronous to clk and start is only given
   while the engine is idle.
*/
`timescale 1ns/100ps
`include "flash_host_regs.svh"

module flash_cycle_engine
   import flash_host_pkg::*;
#(
   parameter int RD_CYC = `T_ACC_CYC,
   parameter int WR_CYC = `T_WP_CYC
)(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic is_write,
   input wire logic [`FLASH_ADDR_W-1:0] addr,
   input wire logic [`FLASH_DATA_W-1:0] wdata,
   input wire logic [`FLASH_DATA_W-1:0] dq_in,
   output logic done,
   output logic [`FLASH_DATA_W-1:0] rdata_ff,
   output flash_pins_type pins_ff
);

   eng_state_type state_ff, nxt_state;
   logic [3:0] cnt_ff, nxt_cnt;
   logic wr_ff, nxt_wr;
   logic [`FLASH_DATA_W-1:0] nxt_rdata;
   flash_pins_type nxt_pins;
   flash_pins_type pins_idle;

   // pins parked: no strobe, bus released
   always_comb begin
      pins_idle = '0;
      pins_idle.ce_n = 1'b1;
      pins_idle.oe_n = 1'b1;
      pins_idle.we_n = 1'b1;
   end

   // setup, strobe for the access time (reads) or write pulse time (writes), then one hold cycle
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_wr = wr_ff;
      nxt_rdata = rdata_ff;
      nxt_pins = pins_ff;
      done = 1'b0;
      unique case (state_ff)
         E_IDLE: begin
            if (start) begin
               nxt_pins.addr = addr;
               nxt_pins.dq_out = wdata;
               nxt_pins.dq_oe = is_write;
               nxt_pins.ce_n = 1'b0;
               nxt_wr = is_write;
               nxt_state = E_SETUP;
            end
         end
         E_SETUP: begin
            nxt_pins.we_n = ~wr_ff;
            nxt_pins.oe_n = wr_ff;
            nxt_cnt = wr_ff ? 4'(WR_CYC - 1) : 4'(RD_CYC - 1);
            nxt_state = E_STROBE;
         end
         E_STROBE: begin
            if (cnt_ff == 4'h0) begin
               if (!wr_ff) begin
                  nxt_rdata = dq_in; // sampled at the end of the access time
               end
               nxt_pins.we_n = 1'b1;
               nxt_pins.oe_n = 1'b1;
               nxt_state = E_HOLD;
            end else begin
               nxt_cnt = cnt_ff - 4'h1;
            end
         end
         E_HOLD: begin
            // data held past the we_n rise, then the bus is released
            nxt_pins = pins_idle;
            nxt_pins.addr = pins_ff.addr;
            done = 1'b1;
            nxt_state = E_IDLE;
         end
      endcase
   end

   // registers of the engine
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= E_IDLE;
         cnt_ff <= 4'h0;
         wr_ff <= 1'b0;
         rdata_ff <= 8'h00;
         pins_ff <= '{addr: '0, dq_out: '0, dq_oe: 1'b0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         wr_ff <= nxt_wr;
         rdata_ff <= nxt_rdata;
         pins_ff <= nxt_pins;
      end
   end

endmodule

/* src/flash_status_host.sv */
/*
   Host-side controller for a parallel flash that reports program and erase
   progress on its data pins. Software on a classic wishbone bus starts single
   flash cycles, a toggle-bit status poll with failure recovery, or the
   addition of a sector to a pending sector erase with window checks.
   Assumes the flash pins are synchronous to clk and that software starts a
   new operation only when the busy bit reads zero.

*/
`timescale 1ns/100ps
`include "flash_host_regs.svh"

module flash_status_host
   import flash_host_pkg::*;
#(
   parameter int RD_CYC = `T_ACC_CYC,
   parameter int WR_CYC = `T_WP_CYC
)(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output flash_pins_type flash_o,
   input wire logic [`FLASH_DATA_W-1:0] flash_dq_i,
   input wire logic ready_busy_n
);

   // byte-lane merge of a write into a register
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat, input logic [3:0] sel);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            res[i*8 +: 8] = dat[i*8 +: 8];
         end
      end
      return res;
   endfunction

   seq_state_type state_ff, nxt_state;
   op_type op_ff, nxt_op;
   logic skip_ff, nxt_skip;
   logic wait_ff, nxt_wait;
   logic prev_ff, nxt_prev;
   logic done_ff, nxt_done;
   logic fail_ff, nxt_fail;
   logic late_ff, nxt_late;
   logic lost_ff, nxt_lost;
   logic [`FLASH_DATA_W-1:0] last_ff, nxt_last;
   logic [`FLASH_ADDR_W-1:0] addr_ff, nxt_addr;
   logic [`FLASH_DATA_W-1:0] wdata_ff, nxt_wdata;
   logic [`FLASH_ADDR_W-1:0] saddr_ff, nxt_saddr;
   logic ack_ff, nxt_ack;
   logic [31:0] dat_ff, nxt_dat;
   logic [31:0] rd_mux;
   logic [31:0] status_word;
   logic req, wr_stb, busy;
   op_type wr_op;
   logic eng_start, eng_write, eng_done;
   logic [`FLASH_ADDR_W-1:0] eng_addr;
   logic [`FLASH_DATA_W-1:0] eng_wdata, eng_rdata;

   assign wb_ack_o = ack_ff;
   assign wb_dat_o = dat_ff;
   assign busy = (state_ff != M_IDLE);

   // wishbone slave: answer one cycle after the request, write lands with ack
   assign req = wb_cyc_i & wb_stb_i;
   assign wr_stb = req & wb_we_i & ack_ff;
   assign wr_op = op_type'(wb_dat_i[`CTRL_OP_MSB:`CTRL_OP_LSB]);

   // status word: progress flags, ready/busy pin and last byte from the flash
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[`STAT_BUSY_BIT] = busy;
      status_word[`STAT_DONE_BIT] = done_ff;
      status_word[`STAT_FAIL_BIT] = fail_ff;
      status_word[`STAT_LATE_BIT] = late_ff;
      status_word[`STAT_LOST_BIT] = lost_ff;
      status_word[`STAT_RDY_BIT] = ready_busy_n; // low while programming or erasing
      status_word[`STAT_LAST_MSB:`STAT_LAST_LSB] = last_ff;
   end

   // read decode; unmapped offsets read zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (wb_adr_i)
         `OFF_CTRL: begin
            rd_mux[`CTRL_OP_MSB:`CTRL_OP_LSB] = op_ff;
            rd_mux[`CTRL_SKIP_WIN_BIT] = skip_ff;
         end
         `OFF_ADDR: rd_mux[`FLASH_ADDR_W-1:0] = addr_ff;
         `OFF_WDATA: rd_mux[`FLASH_DATA_W-1:0] = wdata_ff;
         `OFF_STATUS: rd_mux = status_word;
         `OFF_STAT_ADDR: rd_mux[`FLASH_ADDR_W-1:0] = saddr_ff;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // ack and read data registers
   always_comb begin
      nxt_ack = req & ~ack_ff;
      nxt_dat = dat_ff;
      if (req & ~ack_ff & ~wb_we_i) begin
         nxt_dat = rd_mux;
      end
   end

   // what the engine runs in each state; status reads go to a valid address
   always_comb begin
      eng_start = busy & ~wait_ff;
      eng_write = 1'b0;
      eng_addr = saddr_ff;
      eng_wdata = wdata_ff;
      unique case (state_ff)
         M_IDLE: eng_start = 1'b0;
         M_XFER: begin
            eng_write = (op_ff == OP_WRITE);
            eng_addr = addr_ff;
         end
         M_P_FIRST, M_P_NEXT, M_P_RECHK: eng_addr = saddr_ff;
         M_P_RST: begin
            eng_write = 1'b1;
            eng_wdata = `FL_CMD_RESET; // back to array reads after a failure
         end
         M_S_PRE, M_S_POST: eng_addr = addr_ff;
         M_S_WR: begin
            eng_write = 1'b1;
            eng_addr = addr_ff;
            eng_wdata = `FL_CMD_SECT_ERASE;
         end
      endcase
   end

   // register writes, operation start and the sequencer
   always_comb begin
      nxt_state = state_ff;
      nxt_op = op_ff;
      nxt_skip = skip_ff;
      nxt_prev = prev_ff;
      nxt_done = done_ff;
      nxt_fail = fail_ff;
      nxt_late = late_ff;
      nxt_lost = lost_ff;
      nxt_last = last_ff;
      nxt_addr = addr_ff;
      nxt_wdata = wdata_ff;
      nxt_saddr = saddr_ff;
      nxt_wait = eng_start ? 1'b1 : (eng_done ? 1'b0 : wait_ff);
      // operands are frozen while an operation runs
      if (wr_stb && !busy) begin
         if (wb_adr_i == `OFF_ADDR) begin
            nxt_addr = `FLASH_ADDR_W'(merge(32'(addr_ff), wb_dat_i, wb_sel_i));
         end
         if (wb_adr_i == `OFF_WDATA && wb_sel_i[0]) begin
            nxt_wdata = wb_dat_i[`FLASH_DATA_W-1:0];
         end
         if (wb_adr_i == `OFF_STAT_ADDR) begin
            nxt_saddr = `FLASH_ADDR_W'(merge(32'(saddr_ff), wb_dat_i, wb_sel_i));
         end
         if (wb_adr_i == `OFF_CTRL && wb_sel_i[0] && wr_op != OP_NONE) begin
            nxt_op = wr_op;
            nxt_skip = wb_dat_i[`CTRL_SKIP_WIN_BIT];
            nxt_done = 1'b0;
            nxt_fail = 1'b0;
            nxt_late = 1'b0;
            nxt_lost = 1'b0;
            unique case (wr_op)
               OP_WRITE, OP_READ: nxt_state = M_XFER;
               OP_POLL: nxt_state = M_P_FIRST;
               // fast back-to-back sector commands need no window
               OP_SECTOR: nxt_state = wb_dat_i[`CTRL_SKIP_WIN_BIT] ? M_S_WR : M_S_PRE;
               default: nxt_state = M_IDLE;
            endcase
         end
      end
      if (eng_done) begin
         unique case (state_ff)
            M_IDLE: nxt_state = M_IDLE;
            M_XFER: begin
               if (op_ff == OP_READ) begin
                  nxt_last = eng_rdata;
               end
               nxt_done = 1'b1;
               nxt_state = M_IDLE;
            end
            M_P_FIRST: begin
               nxt_last = eng_rdata;
               nxt_prev = eng_rdata[`DQ_TOGGLE_BIT];
               nxt_state = M_P_NEXT;
            end
            M_P_NEXT: begin
               nxt_last = eng_rdata;
               nxt_prev = eng_rdata[`DQ_TOGGLE_BIT];
               if (eng_rdata[`DQ_TOGGLE_BIT] == prev_ff) begin
                  nxt_done = 1'b1; // toggling stopped: operation complete
                  nxt_state = M_IDLE;
               end else if (eng_rdata[`DQ_TOUT_BIT]) begin
                  nxt_state = M_P_RECHK; // timeout bit seen, toggle may just have stopped
               end
            end
            M_P_RECHK: begin
               nxt_last = eng_rdata;
               if (eng_rdata[`DQ_TOGGLE_BIT] == prev_ff) begin
                  nxt_done = 1'b1;
                  nxt_state = M_IDLE;
               end else begin
                  nxt_state = M_P_RST; // still toggling with timeout: failed
               end
            end
            M_P_RST: begin
               nxt_fail = 1'b1;
               nxt_done = 1'b1;
               nxt_state = M_IDLE;
            end
            M_S_PRE: begin
               nxt_last = eng_rdata;
               if (eng_rdata[`DQ_WIN_BIT]) begin
                  // erase already running, a new sector would be ignored
                  nxt_late = 1'b1;
                  nxt_done = 1'b1;
                  nxt_state = M_IDLE;
               end else begin
                  nxt_state = M_S_WR; // window open, sector can be added
               end
            end
            M_S_WR: begin
               nxt_done = skip_ff;
               nxt_state = skip_ff ? M_IDLE : M_S_POST;
            end
            M_S_POST: begin
               nxt_last = eng_rdata;
               // window closed around our command: it may not have been taken
               // the same byte must show erase status, else the command was not seen
               nxt_lost = eng_rdata[`DQ_WIN_BIT] | eng_rdata[`DQ_POLL_BIT];
               nxt_done = 1'b1;
               nxt_state = M_IDLE;
            end
         endcase
      end
   end

   // registers of the controller
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= M_IDLE;
         op_ff <= OP_NONE;
         skip_ff <= 1'b0;
         wait_ff <= 1'b0;
         prev_ff <= 1'b0;
         done_ff <= 1'b0;
         fail_ff <= 1'b0;
         late_ff <= 1'b0;
         lost_ff <= 1'b0;
         last_ff <= 8'h00;
         addr_ff <= '0;
         wdata_ff <= 8'h00;
         saddr_ff <= '0;
         ack_ff <= 1'b0;
         dat_ff <= 32'h0000_0000;
      end else begin
         state_ff <= nxt_state;
         op_ff <= nxt_op;
         skip_ff <= nxt_skip;
         wait_ff <= nxt_wait;
         prev_ff <= nxt_prev;
         done_ff <= nxt_done;
         fail_ff <= nxt_fail;
         late_ff <= nxt_late;
         lost_ff <= nxt_lost;
         last_ff <= nxt_last;
         addr_ff <= nxt_addr;
         wdata_ff <= nxt_wdata;
         saddr_ff <= nxt_saddr;
         ack_ff <= nxt_ack;
         dat_ff <= nxt_dat;
      end
   end

   // one flash bus cycle per request; each read is a fresh read cycle
   flash_cycle_engine #(
      .RD_CYC(RD_CYC),
      .WR_CYC(WR_CYC)
   ) u_engine (
      .clk(clk),
      .rst_n(rst_n),
      .start(eng_start),
      .is_write(eng_write),
      .addr(eng_addr),
      .wdata(eng_wdata),
      .dq_in(flash_dq_i),
      .done(eng_done),
      .rdata_ff(eng_rdata),
      .pins_ff(flash_o)
   );

endmodule

/* verification/flash_device_model.sv */
/*
   Behavioural model of the parallel flash: small array, program, sector and
   chip erase, with status bytes in place of data while busy.
   Assumes the controller's pins are synchronous to clk; no erase suspend.
*/
`timescale 1ns/100ps
`include "flash_host_regs.svh"

module flash_device_model
   import flash_host_pkg::*;
#(
   parameter int PROG_RD = 4,
   parameter int FAIL_RD = 3,
   parameter int WIN_CYC = 200,
   parameter int ERASE_RD = 6,
   parameter logic [7:0] CHIP_CMD = 8'h10
)(
   input wire logic clk,
   input wire logic rst_n,
   input wire flash_pins_type pins,
   output logic [7:0] dq,
   output logic ready_busy_n
);
   logic [7:0] mem [16];
   logic [63:0] sel;
   logic [1:0] mode; // 0 array, 1 program, 2 erase window, 3 erasing
   logic [15:0] cnt;
   logic [7:0] dq_r;
   logic [7:0] pdata;
   logic tog, stog, bad, fail, prev_oe, prev_we, hit;
   assign hit = sel[pins.addr[21:16]];
   // a released bus shows the inverse of the last byte, never a stale copy
   assign dq = (!pins.ce_n && !pins.oe_n) ? dq_r : ~dq_r;
   assign ready_busy_n = (mode == 2'h0);

   // reads on a falling output enable, commands on a rising write strobe
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode <= 2'h0;
         cnt <= 16'h0;
         sel <= 64'h0;
         {dq_r, pdata, tog, stog, bad, fail} <= 20'h0;
         {prev_oe, prev_we} <= 2'h3;
         for (int i = 0; i < 16; i++) mem[i] <= 8'hFF;
      end else begin
         prev_oe <= pins.oe_n;
         prev_we <= pins.we_n;
         if (mode == 2'h2) begin
            cnt <= cnt + 16'h1;
            if (cnt == 16'(WIN_CYC - 1)) begin
               mode <= 2'h3; // window over, erase begins
               cnt <= 16'h0;
            end
         end
         if (!pins.ce_n && !pins.oe_n && prev_oe) begin
            case (mode) // status replaces data while busy
               2'h0: dq_r <= mem[pins.addr[3:0]];
               // erase-suspend programming would answer with this same byte
               2'h1: dq_r <= {~pdata[7], tog, fail, 5'h00};
               default: dq_r <= {2'b00 | tog, 2'b00, mode[0], hit & stog, 2'h0};
            endcase
            if (mode != 2'h0) tog <= ~tog;
            if (mode[1] && hit) stog <= ~stog;
            if (mode[0]) cnt <= cnt + 16'h1;
            if (mode == 2'h1 && !bad && cnt == 16'(PROG_RD - 1)) mode <= 2'h0;
            if (mode == 2'h1 && bad && cnt == 16'(FAIL_RD - 1)) fail <= 1'b1;
            if (mode == 2'h3 && cnt == 16'(ERASE_RD - 1)) begin
               mode <= 2'h0;
               for (int i = 0; i < 16; i++) mem[i] <= 8'hFF;
            end
         end
         if (!pins.ce_n && pins.we_n && !prev_we) begin
            if (pins.dq_out == `FL_CMD_RESET && mode != 2'h3) begin
               mode <= 2'h0;
               fail <= 1'b0;
            end else if (mode == 2'h0 && pins.dq_out == `FL_CMD_SECT_ERASE) begin
               mode <= 2'h2;
               sel <= 64'h1 << pins.addr[21:16];
               cnt <= 16'h0;
            end else if (mode == 2'h0 && pins.dq_out == CHIP_CMD) begin
               mode <= 2'h3; // chip erase skips the window
               sel <= '1;
               cnt <= 16'h0;
            end else if (mode == 2'h0) begin
               pdata <= pins.dq_out;
               bad <= |(pins.dq_out & ~mem[pins.addr[3:0]]);
               mem[pins.addr[3:0]] <= mem[pins.addr[3:0]] & pins.dq_out;
               mode <= 2'h1;
               cnt <= 16'h0;
            end else if (mode == 2'h2 && pins.dq_out == `FL_CMD_SECT_ERASE) begin
               sel[pins.addr[21:16]] <= 1'b1;
               cnt <= 16'h0;
            end
            // other commands while erasing fall through unheard
         end
      end
   end
endmodule

/* verification/flash_status_host_sva.sv */
/*
   Checker of the controller's wishbone handshake and flash bus cycles.
   Assumes it is bound to flash_status_host and sees only its ports.
*/
`timescale 1ns/100ps

module flash_status_host_sva
   import flash_host_pkg::*;
#(
   parameter int RD_CYC = 2,
   parameter int WR_CYC = 1
)(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire flash_pins_type flash_o
);
   logic [7:0] strobe_cnt_ff;
   logic [7:0] nxt_strobe_cnt;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   // length of the current read or write strobe, for the width checks
   always_comb nxt_strobe_cnt = (!flash_o.oe_n || !flash_o.we_n) ? strobe_cnt_ff + 8'h1 : 8'h00;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) strobe_cnt_ff <= 8'h00;
      else strobe_cnt_ff <= nxt_strobe_cnt;
   end

   sequence s_strobe_on;
      !flash_o.oe_n || !flash_o.we_n;
   endsequence

   a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack not one cycle after request");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_read_len: assert property ($rose(flash_o.oe_n) |-> strobe_cnt_ff == RD_CYC)
      else $error("read strobe length wrong");
   a_write_len: assert property ($rose(flash_o.we_n) |-> strobe_cnt_ff == WR_CYC)
      else $error("write strobe length wrong");
   a_read_no_drive: assert property (!flash_o.oe_n |-> flash_o.we_n && !flash_o.ce_n && !flash_o.dq_oe)
      else $error("read strobe with write or drive");
   a_ce_setup: assert property ($fell(flash_o.ce_n) |-> flash_o.oe_n && flash_o.we_n ##1 s_strobe_on)
      else $error("strobe not one cycle after chip enable");
   a_ce_release: assert property ($rose(flash_o.oe_n) || $rose(flash_o.we_n) |=> $rose(flash_o.ce_n))
      else $error("chip enable not released after strobe");
   // one idle chip enable cycle is enough to make the next read a fresh cycle
   a_ce_gap: assert property ($rose(flash_o.ce_n) |-> flash_o.oe_n && flash_o.we_n && !flash_o.dq_oe)
      else $error("strobe or drive left at chip enable release");
   a_addr_hold: assert property (!flash_o.ce_n && !$past(flash_o.ce_n) |-> $stable(flash_o.addr))
      else $error("address moved within a cycle");
   a_wdata_hold: assert property (!flash_o.we_n |-> flash_o.dq_oe && $stable(flash_o.dq_out))
      else $error("write data not held");
endmodule

/* verification/flash_status_host_tb.sv */
/*
   Testbench of flash_status_host with a flash model on its pins; software
   is played by wishbone tasks. Assumes a 20 MHz clock and model defaults.
*/
`timescale 1ns/100ps
`include "flash_host_regs.svh"

module flash_status_host_tb
   import flash_host_pkg::*;
;
   logic clk, rst_n, wb_cyc, wb_stb, wb_we, wb_ack, rbn;
   logic [7:0] wb_adr, dq;
   logic [3:0] wb_sel;
   logic [31:0] wb_dat, wb_rd;
   flash_pins_type flash_o;
   int failures = 0;
   int n_compared = 0;

   flash_status_host flash_status_host_inst (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_rd),
      .wb_ack_o(wb_ack), .flash_o(flash_o), .flash_dq_i(dq), .ready_busy_n(rbn));
   flash_device_model flash_device_model_inst (.clk(clk), .rst_n(rst_n), .pins(flash_o), .dq(dq),
      .ready_busy_n(rbn));

   always #25 clk = ~clk;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] mask, input string what);
      n_compared++;
      if ((got & mask) !== exp) begin
         failures++;
         $display("unexpected at %0t: %s got %h", $time, what, got);
      end
   endtask

   // one classic cycle; request held until ack is sampled high
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
      int n;
      n = 0;
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_dat <= wd;
      do begin
         @(posedge clk);
         n++;
      end while (wb_ack !== 1'b1 && n < 16);
      if (n >= 16) chk(32'h1, 32'h0, 32'h1, "no ack");
      rd = wb_rd;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
      logic [31:0] x;
      wb(1'b1, adr, wd, x);
   endtask

   // start an operation and wait, bounded, until busy drops
   task automatic op(input logic [31:0] ctrl, output logic [31:0] st);
      int n;
      n = 0;
      wr(`OFF_CTRL, ctrl);
      do begin
         wb(1'b0, `OFF_STATUS, 32'h0, st);
         n++;
      end while (st[`STAT_BUSY_BIT] !== 1'b0 && n < 400);
      if (n >= 400) chk(32'h1, 32'h0, 32'h1, "stuck busy");
   endtask

   task automatic fop(input logic [31:0] adr, input logic [7:0] d, input op_type o, output logic [31:0] st);
      wr(`OFF_ADDR, adr);
      wr(`OFF_WDATA, {24'h0, d});
      op({29'h0, o}, st);
   endtask

   task automatic t_reset();
      logic [31:0] st;
      chk({28'h0, flash_o.ce_n, flash_o.oe_n, flash_o.we_n, flash_o.dq_oe}, 32'hE, 32'hF, "idle pins");
      wb(1'b0, `OFF_STATUS, 32'h0, st);
      chk(st, 32'h20, 32'hFFFF, "status after reset");
      wr(8'h14, 32'h55);
      wb(1'b0, 8'h14, 32'h0, st);
      chk(st, 32'h0, 32'hFFFFFFFF, "unmapped read");
      wr(`OFF_ADDR, 32'hFFFF_FFFF);
      wb(1'b0, `OFF_ADDR, 32'h0, st);
      chk(st, 32'h003F_FFFF, 32'hFFFFFFFF, "address width");
      $display("test reset done");
   endtask

   task automatic t_program();
      logic [31:0] st;
      fop(32'h5, 8'h3C, OP_WRITE, st);
      fop(32'h5, 8'h00, OP_READ, st);
      chk(st, 32'h8000, 32'hA020, "program status");
      wr(`OFF_STAT_ADDR, 32'h5);
      op({29'h0, OP_POLL}, st);
      chk(st, 32'h3C22, 32'hFF3F, "program poll");
      fop(32'h5, 8'hFF, OP_WRITE, st);
      op({29'h0, OP_POLL}, st);
      chk(st, 32'h4, 32'h5, "one over zero fails");
      fop(32'h5, 8'h00, OP_READ, st);
      chk(st, 32'h3C20, 32'hFF21, "array back, zeros kept");
      $display("test program done");
   endtask

   task automatic t_sector();
      logic [31:0] st, s1;
      fop(32'h10000, `FL_CMD_SECT_ERASE, OP_WRITE, st);
      fop(32'h10000, 8'h00, OP_READ, st);
      chk(st, 32'h0, 32'h8808, "window open");
      repeat (100) @(posedge clk);
      wr(`OFF_ADDR, 32'h20000);
      op({29'h0, OP_SECTOR}, st);
      chk(st, 32'h2, 32'h1E, "sector added");
      repeat (60) @(posedge clk);
      fop(32'h20000, 8'h00, OP_READ, st);
      chk(st, 32'h0, 32'h0800, "window restarted");
      repeat (200) @(posedge clk);
      wr(`OFF_ADDR, 32'h30000);
      op({29'h0, OP_SECTOR}, st);
      chk(st, 32'h080A, 32'h881E, "command after window");
      fop(32'h20000, 8'h00, OP_READ, s1);
      fop(32'h20000, 8'h00, OP_READ, st);
      chk(s1 ^ st, 32'h0400, 32'h0400, "sector toggle");
      wr(`OFF_STAT_ADDR, 32'h20000);
      op({29'h0, OP_POLL}, st);
      chk(st, 32'hFF22, 32'hFF3F, "erase done");
      $display("test sector done");
   endtask

   task automatic t_chip();
      logic [31:0] st;
      fop(32'h0, 8'h10, OP_WRITE, st);
      fop(32'h0, 8'h00, OP_READ, st);
      chk(st, 32'h0800, 32'h8820, "chip erase no window");
      op(32'h14, st);
      chk(st, 32'h2, 32'h1E, "blind sector add");
      wr(`OFF_STAT_ADDR, 32'h0);
      op({29'h0, OP_POLL}, st);
      chk(st, 32'hFF22, 32'hFF3F, "chip erase done");
      $display("test chip done");
   endtask

   task automatic final_report();
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat} <= '0;
      wb_sel <= 4'hF;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_reset();
      t_program();
      t_sector();
      t_chip();
      final_report();
   end

   // a hang is cut short well beyond the several hundred cycles expected
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      final_report();
   end
endmodule

bind flash_status_host flash_status_host_sva #(.RD_CYC(RD_CYC), .WR_CYC(WR_CYC)) sva_inst (.clk(clk),
   .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .flash_o(flash_o));
